// File: adc_seq_pkg.sv
// Purpose : shared constants and types for the converter sequencer
// Assumes : 8-bit register port, mclk is the system clock (Fosc)
// Notes   : offsets are register indices on the plain register port

package adc_seq_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [2:0] ADR_CONVERTER_CONTROL = 3'h0;
  localparam logic [2:0] ADR_ANALOG_SELECT     = 3'h1;
  localparam logic [2:0] ADR_PERIPHERAL_FLAG   = 3'h2;
  localparam logic [2:0] ADR_PERIPHERAL_ENABLE = 3'h3;
  localparam logic [2:0] ADR_RESULT_HIGH       = 3'h4;
  localparam logic [2:0] ADR_RESULT_LOW        = 3'h5;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL_JUSTIFY_BIT = 7;
  localparam int CTL_REF_BIT     = 6;
  localparam int CTL_CHAN_LSB    = 2;
  localparam int CTL_GO_BIT      = 1;
  localparam int CTL_ENABLE_BIT  = 0;
  localparam int SEL_CLK_LSB     = 4;
  localparam int SEL_PINS_LSB    = 0;
  localparam int DONE_FLAG_BIT   = 6;
  localparam int IRQ_ENABLE_BIT  = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONVERTER_CONTROL = 8'h00;
  localparam logic [2:0] RST_CLOCK_SELECT      = 3'h0;
  localparam logic [3:0] RST_ANALOG_PINS       = 4'hF;
  localparam logic [9:0] RST_RESULT            = 10'h000;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CHAN_RESERVED   = 3'h7;
  localparam logic [3:0] MODE_SPECIAL    = 4'hB;
  localparam logic [2:0] CLK_DIV_2       = 3'h0;
  localparam logic [2:0] CLK_DIV_4       = 3'h4;
  localparam logic [2:0] CLK_DIV_8       = 3'h1;
  localparam logic [2:0] CLK_DIV_16      = 3'h5;
  localparam logic [2:0] CLK_DIV_32      = 3'h2;
  localparam logic [2:0] CLK_DIV_64      = 3'h6;
  localparam logic [1:0] CLK_RC_SUFFIX   = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS   = 25;
  localparam int         RC_TAD_NS       = 4000;
  localparam logic [8:0] RC_TAD_CYCLES   = 9'(RC_TAD_NS / CLK_PERIOD_NS);
  localparam logic [8:0] INSTR_CYCLES    = 9'h004;
  localparam logic [3:0] CONV_TADS       = 4'hB;
  localparam logic [3:0] ABORT_TADS      = 4'h2;
  localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_DELAY   = 2'b01,
    ST_CONVERT = 2'b11,
    ST_BLANK   = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic       power;
    logic       acquire;
    logic       ext_ref;
    logic       chan_valid;
    logic [2:0] chan;
    logic [9:0] trial_code;
  } analog_ctrl_t;

endpackage : adc_seq_pkg

// File: adc_conversion_sequencer.sv
// Purpose : control and sequencing of a 10-bit successive-approximation converter
// Assumes : comparator answer is valid at the end of each bit period
// Notes   : the RC bit clock is modelled as a fixed count of mclk cycles

`timescale 1ns/1ps

// Operation
// - channel codes route inputs and references
// - reference bit picks external pin or supply
// - clock field selects divider or RC
// - conversion lasts exactly eleven bit periods
// - done flag set regardless of enable
// - completion wakes sleep when enabled
// - left justified result layout
// - right justified result layout
// - enable bit powers the converter
// - status bit starts, reads busy
// - completion clears status, flags, loads result
// - abort keeps previous result
// - abort blanks two periods then acquires
// - reset restores registers, stops conversion
// - RC clock delays start one instruction
// - RC sleep without irq powers off
// - non-RC sleep aborts and powers off
// - special trigger starts conversion, clears timer
// - special trigger only when enabled
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // register port
  input  wire logic [2:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  output logic      [7:0]   reg_rdata,
  // device state
  input  wire logic         sleep_active,
  input  wire logic         global_irq_enable,
  output logic              wake_request,
  output logic              vector_to_isr,
  // compare unit
  input  wire logic [3:0]   compare_unit_mode_field,
  input  wire logic         compare_match,
  output logic              timer_clear,
  // analog side
  input  wire logic         comparator_above,
  output analog_ctrl_t      analog_ctrl,
  output logic      [3:0]   analog_select_pins
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [8:0] tad_length(input logic [2:0] sel);
    logic [8:0] len;
    len = RC_TAD_CYCLES;
    unique case (sel)
      CLK_DIV_2:  len = 9'h002;
      CLK_DIV_4:  len = 9'h004;
      CLK_DIV_8:  len = 9'h008;
      CLK_DIV_16: len = 9'h010;
      CLK_DIV_32: len = 9'h020;
      CLK_DIV_64: len = 9'h040;
      default:    len = RC_TAD_CYCLES;
    endcase
    return len;
  endfunction : tad_length

  function automatic logic [7:0] result_high(input logic [9:0] res, input logic right);
    return right ? {6'h00, res[9:8]} : res[9:2];
  endfunction : result_high

  function automatic logic [7:0] result_low(input logic [9:0] res, input logic right);
    return right ? res[7:0] : {res[1:0], 6'h00};
  endfunction : result_low

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  seq_state_t  state_ff;
  logic        result_justify_select_ff;
  logic        positive_reference_select_ff;
  logic [2:0]  input_channel_select_ff;
  logic        go_ff;
  logic        converter_enable_bit_ff;
  logic [2:0]  conversion_clock_select_ff;
  logic [3:0]  analog_pins_ff;
  logic        conversion_done_flag_ff;
  logic        conversion_irq_enable_ff;
  logic        power_down_ff;
  logic [9:0]  result_ff;
  logic [9:0]  sar_ff;
  logic [8:0]  div_cnt_ff;
  logic [3:0]  tad_cnt_ff;
  logic [7:0]  rdata_ff;
  logic        timer_clear_ff;
  logic        wake_ff;
  logic        isr_ff;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic       wr_ctrl;
  logic       busy;
  logic       rc_sel;
  logic       tad_tick;
  logic       special_trigger;
  logic       abort_sw;
  logic       kill;
  logic       done_pulse;
  logic [3:0] bit_pos;
  logic [9:0] sar_keep;

  assign wr_ctrl  = reg_write && (reg_addr == ADR_CONVERTER_CONTROL);
  assign busy     = (state_ff == ST_DELAY) || (state_ff == ST_CONVERT);
  assign rc_sel   = (conversion_clock_select_ff[1:0] == CLK_RC_SUFFIX);
  assign tad_tick = (div_cnt_ff == tad_length(conversion_clock_select_ff) - 9'h001);

  assign special_trigger = compare_match && converter_enable_bit_ff
                           && (compare_unit_mode_field == MODE_SPECIAL);

  assign abort_sw = wr_ctrl && !reg_wdata[CTL_GO_BIT] && busy;

  assign kill = busy && !abort_sw
                && ((sleep_active && !rc_sel) || !converter_enable_bit_ff);

  assign done_pulse = (state_ff == ST_CONVERT) && tad_tick && !abort_sw && !kill
                      && (tad_cnt_ff == CONV_TADS - 4'h1);

  assign bit_pos  = CONV_TADS - 4'h1 - tad_cnt_ff;
  assign sar_keep = comparator_above ? sar_ff : (sar_ff & ~(10'h001 << bit_pos));

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // reset restores control
  always_ff @(posedge mclk) begin
    if (reset) begin
      result_justify_select_ff     <= RST_CONVERTER_CONTROL[CTL_JUSTIFY_BIT];
      positive_reference_select_ff <= RST_CONVERTER_CONTROL[CTL_REF_BIT];
      input_channel_select_ff      <= RST_CONVERTER_CONTROL[CTL_CHAN_LSB +: 3];
      converter_enable_bit_ff      <= RST_CONVERTER_CONTROL[CTL_ENABLE_BIT];
    end else if (wr_ctrl) begin
      result_justify_select_ff     <= reg_wdata[CTL_JUSTIFY_BIT];
      positive_reference_select_ff <= reg_wdata[CTL_REF_BIT];
      input_channel_select_ff      <= reg_wdata[CTL_CHAN_LSB +: 3];
      converter_enable_bit_ff      <= reg_wdata[CTL_ENABLE_BIT];
    end
  end

  // enable is sampled before the write, so go and enable in one write starts nothing
  always_ff @(posedge mclk) begin
    if (reset) begin
      go_ff <= RST_CONVERTER_CONTROL[CTL_GO_BIT];
    end else if (done_pulse || kill) begin
      go_ff <= 1'b0;
    end else if (special_trigger) begin
      go_ff <= 1'b1;
    end else if (wr_ctrl) begin
      go_ff <= reg_wdata[CTL_GO_BIT] && reg_wdata[CTL_ENABLE_BIT]
               && converter_enable_bit_ff;
    end
  end

  // ----------------------------------------------------------------
  // other software registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      conversion_clock_select_ff <= RST_CLOCK_SELECT;
      analog_pins_ff             <= RST_ANALOG_PINS;
      conversion_irq_enable_ff   <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == ADR_ANALOG_SELECT) begin
        conversion_clock_select_ff <= reg_wdata[SEL_CLK_LSB +: 3];
        analog_pins_ff             <= reg_wdata[SEL_PINS_LSB +: 4];
      end
      if (reg_addr == ADR_PERIPHERAL_ENABLE) begin
        conversion_irq_enable_ff <= reg_wdata[IRQ_ENABLE_BIT];
      end
    end
  end

  // only reset or a software write clears it; set wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      conversion_done_flag_ff <= 1'b0;
    end else if (done_pulse) begin
      conversion_done_flag_ff <= 1'b1;
    end else if (reg_write && (reg_addr == ADR_PERIPHERAL_FLAG)) begin
      conversion_done_flag_ff <= reg_wdata[DONE_FLAG_BIT];
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff   <= ST_IDLE;
      div_cnt_ff <= 9'h000;
      tad_cnt_ff <= 4'h0;
      sar_ff     <= 10'h000;
    end else if (abort_sw) begin
      state_ff   <= ST_BLANK;
      div_cnt_ff <= 9'h000;
      tad_cnt_ff <= 4'h0;
    end else if (kill) begin
      state_ff   <= ST_IDLE;
      div_cnt_ff <= 9'h000;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          div_cnt_ff <= 9'h000;
          tad_cnt_ff <= 4'h0;
          if (go_ff && converter_enable_bit_ff && !power_down_ff) begin
            sar_ff   <= SAR_FIRST_TRIAL;
            state_ff <= rc_sel ? ST_DELAY : ST_CONVERT;
          end
        end
        ST_DELAY: begin
          if (div_cnt_ff == INSTR_CYCLES - 9'h001) begin
            div_cnt_ff <= 9'h000;
            state_ff   <= ST_CONVERT;
          end else begin
            div_cnt_ff <= div_cnt_ff + 9'h001;
          end
        end
        ST_CONVERT: begin
          if (tad_tick) begin
            div_cnt_ff <= 9'h000;
            tad_cnt_ff <= tad_cnt_ff + 4'h1;
            // successive approximation, one bit per period after the first
            if (tad_cnt_ff != 4'h0) begin
              sar_ff <= (bit_pos == 4'h0) ? sar_keep
                        : (sar_keep | (10'h001 << (bit_pos - 4'h1)));
            end
            if (done_pulse) begin
              state_ff <= ST_IDLE;
            end
          end else begin
            div_cnt_ff <= div_cnt_ff + 9'h001;
          end
        end
        ST_BLANK: begin
          if (tad_tick) begin
            div_cnt_ff <= 9'h000;
            tad_cnt_ff <= tad_cnt_ff + 4'h1;
            if (tad_cnt_ff == ABORT_TADS - 4'h1) begin
              state_ff <= ST_IDLE;
            end
          end else begin
            div_cnt_ff <= div_cnt_ff + 9'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      result_ff <= RST_RESULT;
    end else if (done_pulse) begin
      result_ff <= sar_keep;
    end
  end

  // ----------------------------------------------------------------
  // sleep power handling
  // ----------------------------------------------------------------
  // power stays off until sleep ends or software rewrites control
  always_ff @(posedge mclk) begin
    if (reset) begin
      power_down_ff <= 1'b0;
    end else if (done_pulse && sleep_active && rc_sel && !conversion_irq_enable_ff) begin
      power_down_ff <= 1'b1;
    end else if (kill && sleep_active) begin
      power_down_ff <= 1'b1;
    end else if (!sleep_active || wr_ctrl) begin
      power_down_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wake_ff <= 1'b0;
      isr_ff  <= 1'b0;
    end else begin
      wake_ff <= sleep_active && conversion_done_flag_ff && conversion_irq_enable_ff;
      isr_ff  <= sleep_active && conversion_done_flag_ff && conversion_irq_enable_ff
                 && global_irq_enable;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      timer_clear_ff <= 1'b0;
    end else begin
      timer_clear_ff <= special_trigger;
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  // result addresses have no write path
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        ADR_CONVERTER_CONTROL: rdata_ff <= {result_justify_select_ff,
                                            positive_reference_select_ff, 1'b0,
                                            input_channel_select_ff, go_ff,
                                            converter_enable_bit_ff};
        ADR_ANALOG_SELECT:     rdata_ff <= {1'b0, conversion_clock_select_ff,
                                            analog_pins_ff};
        ADR_PERIPHERAL_FLAG:   rdata_ff <= {1'b0, conversion_done_flag_ff, 6'h00};
        ADR_PERIPHERAL_ENABLE: rdata_ff <= {1'b0, conversion_irq_enable_ff, 6'h00};
        ADR_RESULT_HIGH:       rdata_ff <= result_high(result_ff, result_justify_select_ff);
        ADR_RESULT_LOW:        rdata_ff <= result_low(result_ff, result_justify_select_ff);
        default:               rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // power follows enable, held off while power_down_ff is set
  always_comb begin
    analog_ctrl.power      = converter_enable_bit_ff && !power_down_ff;
    analog_ctrl.acquire    = analog_ctrl.power && (state_ff == ST_IDLE);
    analog_ctrl.ext_ref    = positive_reference_select_ff;
    analog_ctrl.chan_valid = (input_channel_select_ff != CHAN_RESERVED);
    analog_ctrl.chan       = input_channel_select_ff;
    analog_ctrl.trial_code = sar_ff;
  end

  assign reg_rdata          = rdata_ff;
  assign wake_request       = wake_ff;
  assign vector_to_isr      = isr_ff;
  assign timer_clear        = timer_clear_ff;
  assign analog_select_pins = analog_pins_ff;

endmodule : adc_conversion_sequencer

// File: sar_analog_model.sv
// Purpose : sample-hold and comparator array model
// Assumes : the held input is one level set by the bench
// Notes   : answers at once; it reports below when unpowered or no input
`timescale 1ns/1ps
module sar_analog_model
  import adc_seq_pkg::*;
(
  // converter side
  input  wire analog_ctrl_t ctrl,
  input  wire logic [9:0]   level,
  output logic              above
);
  // no input when off or reserved
  assign above = ctrl.power && ctrl.chan_valid && (level >= ctrl.trial_code);
endmodule : sar_analog_model

// File: adc_seq_checker.sv
// Purpose : port-level checks of the sequencer
// Assumes : one clock, synchronous reset
// Notes   : attached by bind below
`timescale 1ns/1ps
module adc_seq_checker
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic         mclk,
  input wire logic         reset,
  // register port
  input wire logic [2:0]   reg_addr,
  input wire logic         reg_read,
  input wire logic [7:0]   reg_rdata,
  // device state
  input wire logic         sleep_active,
  input wire logic         global_irq_enable,
  input wire logic         wake_request,
  input wire logic         vector_to_isr,
  // compare unit
  input wire logic [3:0]   compare_unit_mode_field,
  input wire logic         compare_match,
  input wire logic         timer_clear,
  // analog side
  input wire analog_ctrl_t analog_ctrl,
  input wire logic [3:0]   analog_select_pins
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic special_hit;
  assign special_hit = compare_match && (compare_unit_mode_field == MODE_SPECIAL);
  sequence s_clear_once;
    timer_clear ##1 !timer_clear;
  endsequence
  a_clear_cause: assert property (
    timer_clear |-> $past(special_hit) || $past(special_hit, 2))
    else $error("timer clear without special trigger");
  a_clear_single: assert property (timer_clear |-> s_clear_once)
    else $error("timer clear longer than one cycle");
  a_chan_none: assert property (
    analog_ctrl.chan_valid == (analog_ctrl.chan != CHAN_RESERVED))
    else $error("channel valid wrong");
  a_off_no_track: assert property (!analog_ctrl.power |-> !analog_ctrl.acquire)
    else $error("tracking while unpowered");
  a_wake_in_sleep: assert property (wake_request |-> $past(sleep_active))
    else $error("wake outside sleep");
  a_isr_global: assert property (vector_to_isr |-> $past(global_irq_enable))
    else $error("vector without global enable");
  a_reserved_read: assert property (
    $past(reg_read) && ($past(reg_addr) >= 3'h6) |-> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  a_reset_state: assert property (disable iff (1'b0) reset |=>
    reg_rdata == 8'h00 && !analog_ctrl.power && !timer_clear && !wake_request
    && analog_select_pins == 4'hF)
    else $error("reset state wrong");
  c_trigger: cover property (special_hit ##[1:2] timer_clear);
endmodule : adc_seq_checker

bind adc_conversion_sequencer adc_seq_checker u_checker (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .sleep_active(sleep_active),
  .global_irq_enable(global_irq_enable), .wake_request(wake_request),
  .vector_to_isr(vector_to_isr), .compare_unit_mode_field(compare_unit_mode_field),
  .compare_match(compare_match), .timer_clear(timer_clear),
  .analog_ctrl(analog_ctrl), .analog_select_pins(analog_select_pins));

// File: tb_top.sv
// Purpose : register-level tests of the sequencer
// Assumes : model answers with a fixed level
// Notes   : a RC bit period is a fixed count of mclk cycles
`timescale 1ns/1ps
module tb_top
  import adc_seq_pkg::*;
;
  logic         mclk = 1'b0;
  logic         reset = 1'b1;
  logic [2:0]   reg_addr = 3'h0;
  logic [7:0]   reg_wdata = 8'h00;
  logic         reg_write = 1'b0;
  logic         reg_read = 1'b0;
  logic [7:0]   reg_rdata;
  logic         sleep_active = 1'b0;
  logic         gie = 1'b0;
  logic         wake_request;
  logic         vector_to_isr;
  logic [3:0]   cmp_mode = 4'h0;
  logic         compare_match = 1'b0;
  logic         timer_clear;
  logic         above;
  analog_ctrl_t analog_ctrl;
  logic [3:0]   analog_select_pins;
  logic [9:0]   level = 10'h000;
  int           err_total = 0;
  int           n_compared = 0;
  int           cyc = 0;
  int           k;
  logic [9:0]   lv_tab [8] = '{10'h3FF, 10'h000, 10'h2A5, 10'h15A, 10'h201, 10'h1FF,
                               10'h0C3, 10'h33C};
  logic [2:0]   ck_tab [6] = '{CLK_DIV_2, CLK_DIV_4, CLK_DIV_8, CLK_DIV_16, CLK_DIV_32,
                               CLK_DIV_64};
  localparam int RC_RUN = 11 * int'(RC_TAD_CYCLES) + int'(INSTR_CYCLES);

  adc_conversion_sequencer DUT (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sleep_active(sleep_active), .global_irq_enable(gie),
    .wake_request(wake_request), .vector_to_isr(vector_to_isr),
    .compare_unit_mode_field(cmp_mode), .compare_match(compare_match),
    .timer_clear(timer_clear), .comparator_above(above), .analog_ctrl(analog_ctrl),
    .analog_select_pins(analog_select_pins));
  sar_analog_model u_analog (.ctrl(analog_ctrl), .level(level), .above(above));

  always #12.5 mclk = ~mclk;
  // the run needs about 9k cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(exp));
  endtask : rd

  // counts edges until tracking resumes
  task automatic run_len(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (analog_ctrl.acquire !== 1'b1 && n < 3000);
  endtask : run_len

  task automatic conv(input logic [2:0] ck, input logic j, input logic [9:0] lv,
                      input int len);
    level <= lv;
    wr(ADR_ANALOG_SELECT, {1'b0, ck, 4'hF});
    wr(ADR_CONVERTER_CONTROL, {j, 7'h01});
    repeat (8) @(posedge mclk);
    wr(ADR_CONVERTER_CONTROL, {j, 7'h03});
    run_len(k);
    chk(16'(k), 16'(len + 1));
    rd(ADR_CONVERTER_CONTROL, {j, 7'h01});
    rd(ADR_PERIPHERAL_FLAG, 8'h40);
    rd(ADR_RESULT_HIGH, j ? {6'h00, lv[9:8]} : lv[9:2]);
    rd(ADR_RESULT_LOW, j ? lv[7:0] : {lv[1:0], 6'h00});
    wr(ADR_PERIPHERAL_FLAG, 8'h00);
    rd(ADR_PERIPHERAL_FLAG, 8'h00);
  endtask : conv

  task automatic trig(input logic [3:0] m, input int exp);
    int hits;
    hits = 0;
    @(posedge mclk);
    cmp_mode <= m;
    compare_match <= 1'b1;
    @(posedge mclk);
    compare_match <= 1'b0;
    repeat (4) begin
      #1;
      if (timer_clear === 1'b1) hits++;
      @(posedge mclk);
    end
    chk(16'(hits), 16'(exp));
  endtask : trig

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk(16'(analog_select_pins), 16'h000F);
    for (int a = 0; a < 8; a++) rd(3'(a), (a == 1) ? 8'h0F : 8'h00);
    wr(ADR_RESULT_HIGH, 8'hFF);
    wr(ADR_RESULT_LOW, 8'hFF);
    rd(ADR_RESULT_HIGH, 8'h00);
    $display("test reset_values done");
    for (int c = 0; c < 8; c++) begin
      wr(ADR_CONVERTER_CONTROL, {1'b0, c[0], 1'b1, 3'(c), 2'b00});
      rd(ADR_CONVERTER_CONTROL, {1'b0, c[0], 1'b0, 3'(c), 2'b00});
      chk(16'({analog_ctrl.power, analog_ctrl.ext_ref, analog_ctrl.chan_valid,
               analog_ctrl.chan}), 16'({1'b0, c[0], c != 7, 3'(c)}));
    end
    wr(ADR_CONVERTER_CONTROL, 8'h03);
    rd(ADR_CONVERTER_CONTROL, 8'h01);
    chk(16'(analog_ctrl.power), 16'h0001);
    $display("test select_codes done");
    for (int i = 0; i < 6; i++) conv(ck_tab[i], i[0], lv_tab[i], 11 * (2 << i));
    conv({1'b0, CLK_RC_SUFFIX}, 1'b0, lv_tab[6], RC_RUN);
    conv({1'b1, CLK_RC_SUFFIX}, 1'b1, lv_tab[7], RC_RUN);
    $display("test conversions done");
    level <= 10'h0AA;
    wr(ADR_ANALOG_SELECT, {1'b0, CLK_DIV_2, 4'hF});
    wr(ADR_CONVERTER_CONTROL, 8'h83);
    repeat (5) @(posedge mclk);
    wr(ADR_CONVERTER_CONTROL, 8'h81);
    run_len(k);
    // abort acts at its own write edge, so no start edge is added here
    chk(16'(k), 16'(2 * 2));
    rd(ADR_RESULT_HIGH, {6'h00, lv_tab[7][9:8]});
    rd(ADR_RESULT_LOW, lv_tab[7][7:0]);
    rd(ADR_PERIPHERAL_FLAG, 8'h00);
    $display("test abort done");
    wr(ADR_CONVERTER_CONTROL, 8'h00);
    trig(MODE_SPECIAL, 0);
    rd(ADR_CONVERTER_CONTROL, 8'h00);
    wr(ADR_CONVERTER_CONTROL, 8'h01);
    for (int m = 0; m < 16; m++) begin
      trig(4'(m), int'(m == 11));
      if (m == 11) begin
        run_len(k);
        rd(ADR_PERIPHERAL_FLAG, 8'h40);
        wr(ADR_PERIPHERAL_FLAG, 8'h00);
      end else
        rd(ADR_CONVERTER_CONTROL, 8'h01);
    end
    $display("test special_trigger done");
    wr(ADR_CONVERTER_CONTROL, 8'h03);
    repeat (3) @(posedge mclk);
    sleep_active <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(16'(analog_ctrl.power), 16'h0000);
    rd(ADR_CONVERTER_CONTROL, 8'h01);
    rd(ADR_PERIPHERAL_FLAG, 8'h00);
    @(posedge mclk);
    sleep_active <= 1'b0;
    wr(ADR_ANALOG_SELECT, {2'b00, CLK_RC_SUFFIX, 4'hF});
    wr(ADR_PERIPHERAL_ENABLE, 8'h40);
    wr(ADR_CONVERTER_CONTROL, 8'h03);
    @(posedge mclk);
    sleep_active <= 1'b1;
    k = 0;
    while (wake_request !== 1'b1 && k < 2000) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk(16'({wake_request, vector_to_isr}), 16'h0002);
    @(posedge mclk);
    gie <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(16'(vector_to_isr), 16'h0001);
    @(posedge mclk);
    sleep_active <= 1'b0;
    gie <= 1'b0;
    wr(ADR_PERIPHERAL_FLAG, 8'h00);
    wr(ADR_PERIPHERAL_ENABLE, 8'h00);
    wr(ADR_CONVERTER_CONTROL, 8'h03);
    @(posedge mclk);
    sleep_active <= 1'b1;
    repeat (RC_RUN + 8) @(posedge mclk);
    #1;
    chk(16'({analog_ctrl.power, wake_request}), 16'h0000);
    rd(ADR_CONVERTER_CONTROL, 8'h01);
    rd(ADR_PERIPHERAL_FLAG, 8'h40);
    @(posedge mclk);
    sleep_active <= 1'b0;
    $display("test sleep done");
    wr(ADR_CONVERTER_CONTROL, 8'h03);
    repeat (5) @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(ADR_CONVERTER_CONTROL, 8'h00);
    rd(ADR_ANALOG_SELECT, 8'h0F);
    chk(16'(analog_ctrl.power), 16'h0000);
    $display("test midrun_reset done");
    conclude();
  end
endmodule : tb_top
